// >>> design/ddcfg_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module ddcfg_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic      [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             ready_q;
    logic             push;
    logic             pop;

    // Ready is registered from the next count so it comes straight from a flop
    assign push      = in_valid && ready_q;
    assign pop       = out_valid && out_ready;
    assign in_ready  = ready_q;
    assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];
    assign level     = cnt_q;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q    <= '0;
            rd_q    <= '0;
            cnt_q   <= '0;
            ready_q <= 1'b1;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q   <= cnt_d;
            ready_q <= (cnt_d < (AW+1)'(DEPTH));
        end
    end
endmodule // ddcfg_fifo

`default_nettype wire

// >>> design/ddcfg_pkg.sv
// Package for the downconverter channel 0 decimation and oscillator configuration block.
// Assumes a 32-bit classic Wishbone register bus and a sample clock on sys_clk.
//
// Functional notes
// [R1] Bits 5:4 of control select mixing: variable IF, zero Hz, sample-rate, test.
// [R2] Bit 3 clear gives I and Q outputs; set gives I only with extra mixing.
// [R3] Codes 000, 001, 010 enable two, three, four half-band stages.
// [R4] Code 011 enables only the first half-band stage.
// [R5] Codes 100..110 append second third-band after one to three half-bands.
// [R6] Selector 111 takes decimation from extended register bits 7:4.
// [R7] Extended field is ignored unless main selector is all ones.
// [R8] Extended code 0 chains second third-band with all four half-bands.
// [R9] Extended codes 2..4 put fifth-band before one to three half-bands.
// [R10] Extended codes 7..9: first third-band alone, with fifth-band, or plus half-band.
// [R11] Mode 0 takes channel from bits 3:0; mode 3 takes pins A1, A0.
// [R12] Mode 8 counts rising edges of pin A0; mode 9 of pin A1.
// [R13] Counter wraps to zero after reaching the oscillator control bits 3:0.
// [R14] Software must not write unlisted channel-mode or extended codes.
// [R15] Pins are synchronised before rising-edge detection; one count per edge.

package ddcfg_pkg;

    // ****************************************************************
    // Register map (byte addresses = 4 x printed index)
    // ****************************************************************
    localparam logic [11:0] CTRL_IDX   = 12'h310;
    localparam logic [11:0] EXT_IDX    = 12'h311;
    localparam logic [11:0] OSC_IDX    = 12'h314;
    localparam logic [11:0] STAT_IDX   = 12'h320;
    localparam logic [11:0] FIFO_IDX   = 12'h321;
    localparam logic [13:0] CTRL_ADDR  = {CTRL_IDX, 2'b00};
    localparam logic [13:0] EXT_ADDR   = {EXT_IDX, 2'b00};
    localparam logic [13:0] OSC_ADDR   = {OSC_IDX, 2'b00};
    localparam logic [13:0] STAT_ADDR  = {STAT_IDX, 2'b00};
    localparam logic [13:0] FIFO_ADDR  = {FIFO_IDX, 2'b00};
    localparam int          ADDR_W     = 14;

    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [7:0]  EXT_RST    = 8'h00;
    localparam logic [7:0]  OSC_RST    = 8'h00;
    localparam logic [7:0]  EXT_WMASK  = 8'hf0;

    // ****************************************************************
    // Field codes
    // ****************************************************************
    localparam logic [2:0]  DEC_HB12     = 3'h0;
    localparam logic [2:0]  DEC_HB123    = 3'h1;
    localparam logic [2:0]  DEC_HB1234   = 3'h2;
    localparam logic [2:0]  DEC_HB1      = 3'h3;
    localparam logic [2:0]  DEC_HB1_TB2  = 3'h4;
    localparam logic [2:0]  DEC_HB12_TB2 = 3'h5;
    localparam logic [2:0]  DEC_HB123_TB2= 3'h6;
    localparam logic [2:0]  DEC_EXT      = 3'h7;

    localparam logic [3:0]  EXT_TB2_ALL  = 4'h0;
    localparam logic [3:0]  EXT_FB_HB1   = 4'h2;
    localparam logic [3:0]  EXT_FB_HB12  = 4'h3;
    localparam logic [3:0]  EXT_FB_HB123 = 4'h4;
    localparam logic [3:0]  EXT_TB1      = 4'h7;
    localparam logic [3:0]  EXT_TB1_FB   = 4'h8;
    localparam logic [3:0]  EXT_TB1_FB_HB= 4'h9;

    localparam logic [3:0]  CHSEL_REG    = 4'h0;
    localparam logic [3:0]  CHSEL_PINS   = 4'h3;
    localparam logic [3:0]  CHSEL_EDGE0  = 4'h8;
    localparam logic [3:0]  CHSEL_EDGE1  = 4'h9;

    typedef enum logic [1:0] {
        DDCFG_IF_VARIABLE,
        DDCFG_IF_ZERO,
        DDCFG_IF_FS,
        DDCFG_IF_TEST
    } ddcfg_if_mode_t;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    // Stage enables, in order of the chain letters
    typedef struct packed {
        logic halfband_stage_1;
        logic halfband_stage_2;
        logic halfband_stage_3;
        logic halfband_stage_4;
        logic thirdband_stage_1;
        logic thirdband_stage_2;
        logic fifthband_stage;
    } ddcfg_stages_t;

    typedef struct packed {
        ddcfg_if_mode_t if_mode;
        logic           real_only;
        logic           q_valid;
        ddcfg_stages_t  stages;
        logic [5:0]     decim_ratio;
        logic           reserved_code;
        logic [3:0]     osc_channel;
    } ddcfg_cfg_t;

    localparam int CFG_W  = $bits(ddcfg_cfg_t);
    localparam int FIFO_DEPTH = 32;

endpackage

// >>> design/ddcfg_top.sv
// Downconverter channel 0 decimation and oscillator-channel configuration.
// Assumes classic Wishbone at 32 bits, pins synchronous-ish to sys_clk (still
// double-registered), and a sample stream on the same clock.
`timescale 1ns/1ps
`default_nettype none

module ddcfg_top (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [13:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Select pins
    input  wire logic        select_pin_0,
    input  wire logic        select_pin_1,
    // Sample stream: I in [31:16], Q in [15:0]
    input  wire logic        smp_valid,
    output logic             smp_ready,
    input  wire logic [31:0] smp_data,
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic      [31:0] out_data,
    // Configuration towards the datapath
    output ddcfg_pkg::ddcfg_cfg_t cfg_q
);

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] ctrl_q;
    logic [7:0] ext_q;
    logic [7:0] osc_q;
    logic [3:0] count_q;
    logic       req;
    logic       hit_w;

    assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign hit_w = req && wb_we_i && wb_sel_i[0];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= ddcfg_pkg::CTRL_RST;
            ext_q  <= ddcfg_pkg::EXT_RST;
            osc_q  <= ddcfg_pkg::OSC_RST;
        end else if (hit_w) begin
            unique case (wb_adr_i)
                ddcfg_pkg::CTRL_ADDR: ctrl_q <= wb_dat_i[7:0];
                ddcfg_pkg::EXT_ADDR:  ext_q  <= wb_dat_i[7:0] & ddcfg_pkg::EXT_WMASK;
                ddcfg_pkg::OSC_ADDR:  osc_q  <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Bus answer: one wait state, ack for exactly one cycle
    // ****************************************************************
    logic [5:0] fifo_level;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= '0;
            if (req && !wb_we_i) begin
                unique case (wb_adr_i)
                    ddcfg_pkg::CTRL_ADDR: wb_dat_o <= {24'h0, ctrl_q};
                    ddcfg_pkg::EXT_ADDR:  wb_dat_o <= {24'h0, ext_q};
                    ddcfg_pkg::OSC_ADDR:  wb_dat_o <= {24'h0, osc_q};
                    ddcfg_pkg::STAT_ADDR: wb_dat_o <= {24'h0, cfg_q.osc_channel, count_q};
                    ddcfg_pkg::FIFO_ADDR: wb_dat_o <= {26'h0, fifo_level};
                    default:              wb_dat_o <= '0;
                endcase
            end
        end
    end

    // ****************************************************************
    // Pin synchronisers and edge counter
    // ****************************************************************
    logic [1:0] pin_s1_q;
    logic [1:0] pin_s2_q;
    logic [1:0] pin_s3_q;
    logic [1:0] rise;
    logic       step;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
        end else begin
            pin_s1_q <= {select_pin_1, select_pin_0}; // [R15]
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    assign rise = pin_s2_q & ~pin_s3_q; // [R15]
    assign step = (osc_q[7:4] == ddcfg_pkg::CHSEL_EDGE0 && rise[0]) ||
                  (osc_q[7:4] == ddcfg_pkg::CHSEL_EDGE1 && rise[1]); // [R12]

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (step) begin
            count_q <= (count_q >= osc_q[3:0]) ? 4'h0 : count_q + 4'h1; // [R13]
        end
    end

    // ****************************************************************
    // Decimation decode
    // ****************************************************************
    // Ratio shown is the complex-output figure; halved for real output.
    function automatic logic [13:0] main_decode(input logic [2:0] code);
        unique case (code)
            ddcfg_pkg::DEC_HB12:      return {7'b1100000, 6'd4, 1'b0};  // [R3]
            ddcfg_pkg::DEC_HB123:     return {7'b1110000, 6'd8, 1'b0};  // [R3]
            ddcfg_pkg::DEC_HB1234:    return {7'b1111000, 6'd16, 1'b0}; // [R3]
            ddcfg_pkg::DEC_HB1:       return {7'b1000000, 6'd2, 1'b0};  // [R4]
            ddcfg_pkg::DEC_HB1_TB2:   return {7'b1000010, 6'd6, 1'b0};  // [R5]
            ddcfg_pkg::DEC_HB12_TB2:  return {7'b1100010, 6'd12, 1'b0}; // [R5]
            ddcfg_pkg::DEC_HB123_TB2: return {7'b1110010, 6'd24, 1'b0}; // [R5]
            default:                  return '0;
        endcase
    endfunction

    // Third-band-first chains keep their ratio in real mode (no half rate)
    function automatic logic [13:0] ext_decode(input logic [3:0] code);
        unique case (code)
            ddcfg_pkg::EXT_TB2_ALL:   return {7'b1111010, 6'd48, 1'b0}; // [R8]
            ddcfg_pkg::EXT_FB_HB1:    return {7'b1000001, 6'd10, 1'b0}; // [R9]
            ddcfg_pkg::EXT_FB_HB12:   return {7'b1100001, 6'd20, 1'b0}; // [R9]
            ddcfg_pkg::EXT_FB_HB123:  return {7'b1110001, 6'd40, 1'b0}; // [R9]
            ddcfg_pkg::EXT_TB1:       return {7'b0000100, 6'd3, 1'b0};  // [R10]
            ddcfg_pkg::EXT_TB1_FB:    return {7'b0000101, 6'd15, 1'b0}; // [R10]
            ddcfg_pkg::EXT_TB1_FB_HB: return {7'b0100101, 6'd30, 1'b0}; // [R10]
            default:                  return {7'b0000000, 6'd0, 1'b1};  // [R14]
        endcase
    endfunction

    logic [13:0] dec;
    logic        tb1_chain;
    logic        real_en;
    logic [3:0]  chan_d;

    assign real_en   = ctrl_q[3];
    assign dec       = (ctrl_q[2:0] == ddcfg_pkg::DEC_EXT) ? ext_decode(ext_q[7:4]) // [R6] [R7]
                                                          : main_decode(ctrl_q[2:0]);
    assign tb1_chain = dec[9];

    always_comb begin
        unique case (osc_q[7:4])
            ddcfg_pkg::CHSEL_REG:   chan_d = osc_q[3:0];                      // [R11]
            ddcfg_pkg::CHSEL_PINS:  chan_d = {2'b00, pin_s2_q[1], pin_s2_q[0]}; // [R11]
            ddcfg_pkg::CHSEL_EDGE0,
            ddcfg_pkg::CHSEL_EDGE1: chan_d = count_q;                         // [R12]
            default:                chan_d = 4'h0;                            // [R14]
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= '0;
        end else begin
            cfg_q.if_mode       <= ddcfg_pkg::ddcfg_if_mode_t'(ctrl_q[5:4]); // [R1]
            cfg_q.real_only     <= real_en;                                   // [R2]
            cfg_q.q_valid       <= !real_en;                                  // [R2]
            cfg_q.stages        <= dec[13:7];
            cfg_q.decim_ratio   <= (real_en && !tb1_chain) ? {1'b0, dec[6:2]} : dec[6:1];
            cfg_q.reserved_code <= dec[0];
            cfg_q.osc_channel   <= chan_d;
        end
    end

    // ****************************************************************
    // Sample path: Q lane zeroed in real-only mode
    // ****************************************************************
    logic [31:0] smp_masked;

    assign smp_masked = real_en ? {smp_data[31:16], 16'h0} : smp_data; // [R2]

    logic        f_valid;
    logic [31:0] f_data;
    logic        take;

    ddcfg_fifo #(
        .WIDTH (32),
        .DEPTH (ddcfg_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (smp_valid),
        .in_ready  (smp_ready),
        .in_data   (smp_masked),
        .out_valid (f_valid),
        .out_ready (take),
        .out_data  (f_data),
        .level     (fifo_level)
    );

    // Output register stage so the stream outputs come from flops
    assign take = f_valid && (!out_valid || out_ready);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (take) begin
            out_valid <= 1'b1;
            out_data  <= f_data;
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

endmodule // ddcfg_top

`default_nettype wire

// >>> sim/ddcfg_props.sv
// Concurrent checks on the ports of the downconverter configuration block.
// Assumes a bind into ddcfg_top; it sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module ddcfg_props (
    input wire logic                  sys_clk,
    input wire logic                  rst_n,
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic                  wb_we_i,
    input wire logic [13:0]           wb_adr_i,
    input wire logic [3:0]            wb_sel_i,
    input wire logic [31:0]           wb_dat_i,
    input wire logic [31:0]           wb_dat_o,
    input wire logic                  wb_ack_o,
    input wire logic                  select_pin_0,
    input wire logic                  select_pin_1,
    input wire logic                  smp_valid,
    input wire logic                  smp_ready,
    input wire logic [31:0]           smp_data,
    input wire logic                  out_valid,
    input wire logic                  out_ready,
    input wire logic [31:0]           out_data,
    input wire ddcfg_pkg::ddcfg_cfg_t cfg_q
);
    // ****************************************************************
    // Bus handshake, configuration decode and output stream
    // ****************************************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic take_ctrl;
    // Write to the control register taken at this edge
    assign take_ctrl = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
                       && (wb_adr_i == ddcfg_pkg::CTRL_ADDR);

    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    rdata_idle_a: assert property (!(wb_ack_o && !wb_we_i) |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside read ack");
    if_mode_a: assert property (take_ctrl |-> ##2 cfg_q.if_mode == $past(wb_dat_i[5:4], 2))
        else $error("mixing mode not taken from control write");
    real_sel_a: assert property (take_ctrl |-> ##2 (cfg_q.real_only == $past(wb_dat_i[3], 2))
        && (cfg_q.q_valid != cfg_q.real_only)) else $error("real output select wrong");
    hb1_only_a: assert property (take_ctrl && wb_dat_i[2:0] == 3'h3 |-> ##2
        cfg_q.stages == 7'h40 && cfg_q.decim_ratio == ($past(wb_dat_i[3], 2) ? 6'h01 : 6'h02))
        else $error("single half-band decode wrong");
    real_q_zero_a: assert property (out_valid && cfg_q.real_only |-> out_data[15:0] == 16'h0)
        else $error("quadrature not zero in real mode");
    out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("output dropped while stalled");
endmodule // ddcfg_props

bind ddcfg_top ddcfg_props chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .select_pin_0(select_pin_0), .select_pin_1(select_pin_1), .smp_valid(smp_valid),
    .smp_ready(smp_ready), .smp_data(smp_data), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .cfg_q(cfg_q));

`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the downconverter configuration block.
// Assumes ddcfg_top with Wishbone registers, a 32-deep FIFO and two select pins.
`timescale 1ns/1ps
`default_nettype none

module tb;
    // ****************************************************************
    // Stimulus signals, tables and shared tasks
    // ****************************************************************
    logic                  sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic                  select_pin_0, select_pin_1, smp_valid, smp_ready, out_valid, out_ready;
    logic [13:0]           wb_adr_i;
    logic [3:0]            wb_sel_i;
    logic [31:0]           wb_dat_i, wb_dat_o, smp_data, out_data, rd;
    ddcfg_pkg::ddcfg_cfg_t cfg_q;
    int                    n_mismatch, checks, cnt;
    logic [6:0]            st_m [0:6] = '{7'h60, 7'h70, 7'h78, 7'h40, 7'h42, 7'h62, 7'h72};
    logic [5:0]            cr_m [0:6] = '{6'h04, 6'h08, 6'h10, 6'h02, 6'h06, 6'h0c, 6'h18};
    logic [3:0]            ec   [0:6] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9};
    logic [6:0]            st_e [0:6] = '{7'h7a, 7'h41, 7'h61, 7'h71, 7'h04, 7'h05, 7'h25};
    logic [5:0]            cr_e [0:6] = '{6'h30, 6'h0a, 6'h14, 6'h28, 6'h03, 6'h0f, 6'h1e};

    ddcfg_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .select_pin_0(select_pin_0), .select_pin_1(select_pin_1), .smp_valid(smp_valid),
        .smp_ready(smp_ready), .smp_data(smp_data), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data), .cfg_q(cfg_q));

    always #12.5 sys_clk = ~sys_clk;

    task automatic give_verdict;
        if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [13:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        check({31'h0, wb_ack_o}, 32'h1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [13:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hf);
    endtask

    // Configuration lands one edge after the write edge; sample mid-cycle
    task automatic settle;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic pulse(input int p);
        @(posedge sys_clk);
        if (p == 0) select_pin_0 <= 1'b1;
        else select_pin_1 <= 1'b1;
        repeat (6) @(posedge sys_clk);
        select_pin_0 <= 1'b0;
        select_pin_1 <= 1'b0;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset_and_bus;
        wb(1'b0, ddcfg_pkg::CTRL_ADDR, 32'h0, 4'hf);
        check(rd, 32'h0);
        wb(1'b0, ddcfg_pkg::OSC_ADDR, 32'h0, 4'hf);
        check(rd, 32'h0);
        check(32'(cfg_q.stages), 32'h60);
        check(32'(cfg_q.decim_ratio), 32'h4);
        // Unmapped write is dropped, lane 0 off leaves the register alone
        wr(14'h0000, 32'hff);
        wb(1'b0, 14'h0000, 32'h0, 4'hf);
        check(rd, 32'h0);
        wb(1'b1, ddcfg_pkg::CTRL_ADDR, 32'h33, 4'he);
        wb(1'b0, ddcfg_pkg::CTRL_ADDR, 32'h0, 4'hf);
        check(rd, 32'h0);
    endtask

    task automatic t_main_codes;
        for (int c = 0; c < 7; c++) begin
            for (int r = 0; r < 2; r++) begin
                wr(ddcfg_pkg::CTRL_ADDR, {26'h0, 2'(c), 1'(r), 3'(c)});
                settle();
                check(32'(cfg_q.if_mode), 32'(c % 4));
                check({cfg_q.real_only, cfg_q.q_valid}, r ? 32'h2 : 32'h1);
                check(32'(cfg_q.stages), 32'(st_m[c]));
                check(32'(cfg_q.decim_ratio), r ? 32'(cr_m[c] >> 1) : 32'(cr_m[c]));
            end
        end
    endtask

    task automatic t_ext_codes;
        wr(ddcfg_pkg::CTRL_ADDR, 32'h0);
        wr(ddcfg_pkg::EXT_ADDR, 32'hff);
        wb(1'b0, ddcfg_pkg::EXT_ADDR, 32'h0, 4'hf);
        check(rd, 32'hf0);
        wr(ddcfg_pkg::EXT_ADDR, 32'h20);
        settle();
        check(32'(cfg_q.stages), 32'h60);
        for (int r = 0; r < 2; r++) begin
            wr(ddcfg_pkg::CTRL_ADDR, {28'h0, 1'(r), 3'h7});
            for (int i = 0; i < 7; i++) begin
                wr(ddcfg_pkg::EXT_ADDR, {24'h0, ec[i], 4'h0});
                settle();
                check(32'(cfg_q.stages), 32'(st_e[i]));
                check(32'(cfg_q.decim_ratio), (r && i < 4) ? 32'(cr_e[i] >> 1) : 32'(cr_e[i]));
            end
        end
        // Unlisted code is flagged rather than decoded
        wr(ddcfg_pkg::EXT_ADDR, 32'h50);
        settle();
        check({cfg_q.stages, cfg_q.decim_ratio, cfg_q.reserved_code}, 32'h1);
    endtask

    task automatic t_channel;
        wr(ddcfg_pkg::OSC_ADDR, 32'h05);
        settle();
        check(32'(cfg_q.osc_channel), 32'h5);
        wr(ddcfg_pkg::OSC_ADDR, 32'h30);
        for (int p = 0; p < 4; p++) begin
            @(posedge sys_clk);
            select_pin_0 <= p[0];
            select_pin_1 <= p[1];
            repeat (6) @(posedge sys_clk);
            @(negedge sys_clk);
            check(32'(cfg_q.osc_channel), 32'(p));
        end
        @(posedge sys_clk);
        select_pin_0 <= 1'b0;
        select_pin_1 <= 1'b0;
        cnt = 0;
        for (int m = 0; m < 2; m++) begin
            wr(ddcfg_pkg::OSC_ADDR, m ? 32'h92 : 32'h82);
            for (int e = 0; e < 4; e++) begin
                pulse(1 - m);
                check(32'(cfg_q.osc_channel), 32'(cnt));
                pulse(m);
                cnt = (cnt >= 2) ? 0 : cnt + 1;
                check(32'(cfg_q.osc_channel), 32'(cnt));
            end
        end
        wb(1'b0, ddcfg_pkg::STAT_ADDR, 32'h0, 4'hf);
        check(rd, {24'h0, 4'(cnt), 4'(cnt)});
    endtask

    task automatic t_stream;
        int k;
        int j;
        k = 0;
        j = 0;
        wr(ddcfg_pkg::CTRL_ADDR, 32'h0);
        smp_valid <= 1'b1;
        smp_data  <= 32'h00005a5a;
        for (int n = 0; n < 40; n++) begin
            @(negedge sys_clk);
            if (smp_ready) k++;
            @(posedge sys_clk);
            smp_data <= {k[15:0], k[15:0] ^ 16'h5a5a};
        end
        smp_valid <= 1'b0;
        check({31'h0, smp_ready}, 32'h0);
        wb(1'b0, ddcfg_pkg::FIFO_ADDR, 32'h0, 4'hf);
        check(rd, 32'h20);
        out_ready <= 1'b1;
        for (int n = 0; n < 80 && j < k; n++) begin
            @(negedge sys_clk);
            if (out_valid) begin
                check(out_data, {j[15:0], j[15:0] ^ 16'h5a5a});
                j++;
            end
        end
        check(32'(j), 32'(k));
        wr(ddcfg_pkg::CTRL_ADDR, 32'h08);
        settle();
        @(posedge sys_clk);
        smp_valid <= 1'b1;
        smp_data  <= 32'hbeef1234;
        @(posedge sys_clk);
        smp_valid <= 1'b0;
        for (int n = 0; n < 10 && out_valid !== 1'b1; n++) @(negedge sys_clk);
        check(out_data, 32'hbeef0000);
    endtask

    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, select_pin_0, select_pin_1, smp_valid, out_ready} = 7'h0;
        wb_adr_i = 14'h0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        smp_data = 32'h0;
        n_mismatch = 0;
        checks = 0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset_and_bus();
        t_main_codes();
        t_ext_codes();
        t_channel();
        t_stream();
        give_verdict();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        give_verdict();
    end
endmodule // tb

`default_nettype wire
